// File: design/hcr_pkg.sv
/*
 * Package for the reset, reference clock select and PCIe sideband block.
 * Assumes a single 200 MHz system clock and a synchronous high reset.
 */
package hcr_pkg;

    // Reset release stretch after both reset inputs are seen high.
    localparam int RELEASE_NS = 100;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RELEASE_CYCLES =
        ((RELEASE_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RELEASE_COUNT = 8'(RELEASE_CYCLES);

    // PLL multiplier codes chosen by the frequency select strap.
    localparam logic [7:0] PLL_MULT_SEL_LOW = 8'h19;
    localparam logic [7:0] PLL_MULT_SEL_HIGH = 8'h32;

    // Reset values of the sideband outputs and strap capture.
    localparam logic WAKE_RESET_N = 1'b1;
    localparam logic CLKREQ_RESET_N = 1'b1;
    localparam logic [7:0] PLL_MULT_RESET = 8'h00;

    typedef enum logic [1:0] {
        HCR_ST_HELD = 2'b00,
        HCR_ST_STRETCH = 2'b01,
        HCR_ST_RUN = 2'b10
    } hcr_state_e;

    typedef struct packed {
        logic global_power_reset_n;
        logic perst_n;
        logic osc_frequency_select;
    } hcr_pins_s;

    typedef struct packed {
        logic wake_n;
        logic clkreq_n;
    } hcr_side_s;

endpackage

// File: design/hcr_reset_sideband.sv
/*
 * Reset sequencer, frequency strap capture and PCIe sideband drivers.
 * Assumes pins are asynchronous to clk_sys and that the core logic obeys
 * core_rst and func_enable.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Global power reset returns the sequencer and outputs to their defaults; pll_mult instead keeps loading the strap code and the capture chains keep sampling.
// - While global power reset holds, device performs no function.
// - Frequency select strap sets the PLL multiplier.
// - PERST# marks stable system power and yields internal power-on reset.
// - WAKE# driven low requests main power and reference clocks.
// - CLKREQ# requests the PCIe reference clock.
module hcr_reset_sideband #(
    parameter logic [7:0] RELEASE_COUNT = hcr_pkg::RELEASE_COUNT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Board pins
    input wire hcr_pkg::hcr_pins_s pins,
    // Core requests
    input wire logic wake_request,
    input wire logic refclk_request,
    // Sideband pins
    output hcr_pkg::hcr_side_s side,
    // Core control
    output logic core_rst,
    output logic func_enable,
    output logic [7:0] pll_mult
);

    // Raw capture chains; bit 2 holds the oldest sample.
    logic [2:0] sync_gpr;
    logic [2:0] sync_perst;
    logic [2:0] sync_fsel;
    logic [2:0] next_sync_gpr;
    logic [2:0] next_sync_perst;
    logic [2:0] next_sync_fsel;

    // Filtered levels that the rest of the block acts on.
    logic gpr_n;
    logic perst_n;
    logic fsel;
    logic next_gpr_n;
    logic next_perst_n;
    logic next_fsel;

    // Release sequencer.
    hcr_pkg::hcr_state_e state;
    hcr_pkg::hcr_state_e next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic held;

    // Next values of the registered outputs.
    logic [7:0] next_pll_mult;
    hcr_pkg::hcr_side_s next_side;
    logic next_core_rst;
    logic next_func_enable;

    // Three-stage capture; a level counts once stages two and three agree.
    // The agreement filter costs one cycle of latency but keeps a single
    // metastable sample from toggling the core reset for one cycle.
    always_comb begin
        next_sync_gpr = {sync_gpr[1:0], pins.global_power_reset_n};
        next_sync_perst = {sync_perst[1:0], pins.perst_n};
        next_sync_fsel = {sync_fsel[1:0], pins.osc_frequency_select};
        next_gpr_n = gpr_n;
        next_perst_n = perst_n;
        next_fsel = fsel;
        if (sync_gpr[2] == sync_gpr[1]) begin
            next_gpr_n = sync_gpr[2];
        end
        if (sync_perst[2] == sync_perst[1]) begin
            next_perst_n = sync_perst[2];
        end
        if (sync_fsel[2] == sync_fsel[1]) begin
            next_fsel = sync_fsel[2];
        end
    end

    // Resets are taken as asserted until seen high, so the core cannot
    // start for even a cycle before the pins have been sampled.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_gpr <= 3'h0;
            sync_perst <= 3'h0;
            sync_fsel <= 3'h0;
            gpr_n <= 1'b0;
            perst_n <= 1'b0;
            fsel <= 1'b0;
        end else begin
            sync_gpr <= next_sync_gpr;
            sync_perst <= next_sync_perst;
            sync_fsel <= next_sync_fsel;
            gpr_n <= next_gpr_n;
            perst_n <= next_perst_n;
            fsel <= next_fsel;
        end
    end

    assign held = !gpr_n || !perst_n;

    // Any return of either reset during the stretch restarts it, so the
    // core always sees the full stretch after the last pin glitch.
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            hcr_pkg::HCR_ST_HELD: begin
                next_count = 8'h00;
                if (!held) begin
                    next_state = hcr_pkg::HCR_ST_STRETCH;
                end
            end
            hcr_pkg::HCR_ST_STRETCH: begin
                next_count = count + 8'h01;
                if (held) begin
                    next_state = hcr_pkg::HCR_ST_HELD;
                end else if (count == RELEASE_COUNT - 8'h01) begin
                    next_state = hcr_pkg::HCR_ST_RUN;
                end
            end
            hcr_pkg::HCR_ST_RUN: begin
                if (held) begin
                    next_state = hcr_pkg::HCR_ST_HELD;
                end
            end
            default: begin
                next_state = hcr_pkg::HCR_ST_HELD;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= hcr_pkg::HCR_ST_HELD;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // The strap is latched during reset so a late wiggle cannot retune
    // a running PLL.
    always_comb begin
        next_pll_mult = pll_mult;
        if (state != hcr_pkg::HCR_ST_RUN) begin
            next_pll_mult = fsel ? hcr_pkg::PLL_MULT_SEL_HIGH
                                 : hcr_pkg::PLL_MULT_SEL_LOW;
        end
    end

    // A request made while the global power reset is low is dropped, not
    // queued; the core must keep asking once the reset has gone.
    always_comb begin
        next_side = side;
        if (!gpr_n) begin
            next_side.wake_n = hcr_pkg::WAKE_RESET_N;
            next_side.clkreq_n = hcr_pkg::CLKREQ_RESET_N;
        end else begin
            next_side.wake_n = !wake_request;
            next_side.clkreq_n = !refclk_request;
        end
    end

    // Core reset follows the next state so that it and the state change
    // on the same edge.
    always_comb begin
        next_core_rst = (next_state != hcr_pkg::HCR_ST_RUN);
        next_func_enable = (next_state == hcr_pkg::HCR_ST_RUN);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pll_mult <= hcr_pkg::PLL_MULT_RESET;
            side.wake_n <= hcr_pkg::WAKE_RESET_N;
            side.clkreq_n <= hcr_pkg::CLKREQ_RESET_N;
            core_rst <= 1'b1;
            func_enable <= 1'b0;
        end else begin
            pll_mult <= next_pll_mult;
            side <= next_side;
            core_rst <= next_core_rst;
            func_enable <= next_func_enable;
        end
    end

endmodule // hcr_reset_sideband
`default_nettype wire

// File: tb/hcr_reset_sideband_props.sv
/* Checker for the reset sequencer ports.
   Assumes binding onto hcr_reset_sideband. */
`timescale 1ns/1ps
`default_nettype none
module hcr_reset_sideband_props #(
    parameter logic [7:0] RELEASE_COUNT = 8'h14
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire hcr_pkg::hcr_pins_s pins,
    input wire logic wake_request,
    input wire logic refclk_request,
    input wire hcr_pkg::hcr_side_s side,
    input wire logic core_rst,
    input wire logic func_enable,
    input wire logic [7:0] pll_mult
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_gpr_holds_all: assert property (
        !pins.global_power_reset_n [*6] |-> core_rst && side == 2'b11)
        else $error("global reset did not hold outputs");
    a_perst_holds_core: assert property (
        !pins.perst_n [*6] |-> core_rst) else $error("perst ignored");
    a_enable_inverse: assert property (
        func_enable != core_rst) else $error("enable with reset");
    a_wake_follows: assert property (
        pins.global_power_reset_n [*6] |=> side.wake_n == !$past(wake_request))
        else $error("wake not driven");
    a_clkreq_follows: assert property (
        pins.global_power_reset_n [*6]
        |=> side.clkreq_n == !$past(refclk_request)) else $error("clkreq");
    a_pll_from_strap: assert property (
        $fell(core_rst) |-> pll_mult == (pins.osc_frequency_select ?
        hcr_pkg::PLL_MULT_SEL_HIGH : hcr_pkg::PLL_MULT_SEL_LOW))
        else $error("pll code wrong");
    a_release_late: assert property (
        $fell(core_rst) |-> $past(pins.global_power_reset_n && pins.perst_n,
        RELEASE_COUNT + 3)) else $error("release too early");
endmodule // hcr_reset_sideband_props
bind hcr_reset_sideband hcr_reset_sideband_props #(
    .RELEASE_COUNT(RELEASE_COUNT)) u_props (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .pins(pins), .wake_request(wake_request),
    .refclk_request(refclk_request), .side(side), .core_rst(core_rst),
    .func_enable(func_enable), .pll_mult(pll_mult));
`default_nettype wire

// File: tb/hcr_board.sv
/* Board model for the reset and strap pins.
   Assumes the bench sequences power and host reset. */
`timescale 1ns/1ps
`default_nettype none
module hcr_board (
    // Board controls
    input wire logic power_good,
    input wire logic host_perst_n,
    input wire logic fsel_high,
    // Pins
    output hcr_pkg::hcr_pins_s pins,
    // Reference clock pair
    output logic refclk_p,
    output logic refclk_n
);
    initial begin
        refclk_p = 1'b0;
        forever #5 refclk_p = ~refclk_p;
    end
    assign refclk_n = ~refclk_p;
    // reset held until rails and clock good
    assign pins.global_power_reset_n = power_good;
    assign pins.perst_n = host_perst_n;
    // strap low unless a test asks
    assign pins.osc_frequency_select = fsel_high;
endmodule // hcr_board
`default_nettype wire

// File: tb/host_ctrl_reset_clock_sideband_tb.sv
/* Bench for the reset sequencer.
   Assumes the board model and checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_reset_clock_sideband_tb;
    logic clk_sys = 0, sys_rst = 1, pg = 0, perst_n = 0, fsel = 0;
    logic wake_request = 0, refclk_request = 0, core_rst, func_enable;
    logic [7:0] pll_mult;
    logic [3:0] rows [4] = '{4'b0011, 4'b1001, 4'b0110, 4'b1100};
    hcr_pkg::hcr_pins_s pins;
    hcr_pkg::hcr_side_s side;
    int n_mismatch = 0, tests_run = 0;
    always #2.5 clk_sys = ~clk_sys;
    hcr_board board (.power_good(pg), .host_perst_n(perst_n),
        .fsel_high(fsel), .pins(pins), .refclk_p(), .refclk_n());
    hcr_reset_sideband #(.RELEASE_COUNT(8'h02)) DUT (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .pins(pins), .wake_request(wake_request),
        .refclk_request(refclk_request), .side(side), .core_rst(core_rst),
        .func_enable(func_enable), .pll_mult(pll_mult));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic up(input logic fs);
        fsel = fs;
        repeat (8) @(negedge clk_sys);
        {pg, perst_n} = 2'b11;
        for (int i = 0; i < 30 && core_rst !== 1'b0; i++) @(negedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        sys_rst = 0;
        chk({core_rst, side}, 3'b111);
        $display("reset test done");
        up(0);
        chk(func_enable, 1'b1);
        chk(pll_mult, hcr_pkg::PLL_MULT_SEL_LOW);
        foreach (rows[i]) begin
            {wake_request, refclk_request} = rows[i][3:2];
            @(negedge clk_sys);
            chk(side, rows[i][1:0]);
        end
        $display("sideband rows done");
        wake_request = 1;
        perst_n = 0;
        repeat (8) @(negedge clk_sys);
        chk({core_rst, side.wake_n}, 2'b10);
        pg = 0;
        repeat (8) @(negedge clk_sys);
        chk({core_rst, func_enable, side}, 4'b1011);
        wake_request = 0;
        $display("pin reset test done");
        up(1);
        chk(pll_mult, hcr_pkg::PLL_MULT_SEL_HIGH);
        $display("strap test done");
        report_and_stop();
    end
    initial begin
        #5000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // host_ctrl_reset_clock_sideband_tb
`default_nettype wire
